// ---- core/radio_packet_status_regs.sv ----
/*
  Radio packet status register bank: interrupt enable/disable with sticky event
  status, last-packet capture registers and the packet buffer pointer, behind an
  Avalon-MM slave with waitrequest.
  Assumes event strobes and capture values come from radio logic on the same clock,
  each strobe one cycle high, capture values valid in the strobe cycle.
*/
`timescale 1ns/1ps
module radio_packet_status_regs #(
  parameter int LOGICAL_ADDR_W = 3,
  parameter int CHECK_FIELD_W = 24,
  parameter int DEVICE_INDEX_W = 3,
  parameter int SIGNAL_STRENGTH_W = 7,
  parameter int BIT_COUNT_W = 32
) (
  input wire logic CLK,
  input wire logic RST_N,
  // Avalon-MM slave
  input wire logic [radio_status_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [radio_status_pkg::DATA_W-1:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [radio_status_pkg::DATA_W-1:0] READDATA,
  output logic WAITREQUEST,
  // Radio core event strobes
  input wire logic READY_STROBE,
  input wire logic ADDRESS_STROBE,
  input wire logic RECEIVED_A_STROBE,
  input wire logic END_STROBE,
  input wire logic DISABLED_STROBE,
  input wire logic DEVICE_ADDRESS_HIT,
  input wire logic DEVICE_ADDRESS_MISS,
  input wire logic [DEVICE_INDEX_W-1:0] DEVICE_INDEX,
  // Reception end with captured packet facts
  input wire logic RX_DONE,
  input wire logic RX_CHECK_OK,
  input wire logic [LOGICAL_ADDR_W-1:0] RX_LOGICAL_ADDRESS,
  input wire logic [CHECK_FIELD_W-1:0] RX_CHECK_FIELD,
  // Signal strength sampler
  input wire logic SIGNAL_STRENGTH_VALID,
  input wire logic [SIGNAL_STRENGTH_W-1:0] SIGNAL_STRENGTH_VALUE,
  // Received bit counter
  input wire logic BIT_COUNT_STEP,
  input wire logic [BIT_COUNT_W-1:0] BIT_COUNT,
  // Outputs to radio core and processor
  output logic [31:0] PACKET_BUFFER_POINTER,
  output logic IRQ
);
  import radio_status_pkg::*;

  // Elaboration checks, every field must fit one bus word
  if (LOGICAL_ADDR_W < 1 || LOGICAL_ADDR_W > DATA_W)
  begin : g_logical_addr_w_check
    $error("radio_packet_status_regs: LOGICAL_ADDR_W must lie between 1 and 32");
  end

  if (CHECK_FIELD_W < 1 || CHECK_FIELD_W > DATA_W)
  begin : g_check_field_w_check
    $error("radio_packet_status_regs: CHECK_FIELD_W must lie between 1 and 32");
  end

  if (DEVICE_INDEX_W < 1 || DEVICE_INDEX_W > DATA_W)
  begin : g_device_index_w_check
    $error("radio_packet_status_regs: DEVICE_INDEX_W must lie between 1 and 32");
  end

  if (SIGNAL_STRENGTH_W < 1 || SIGNAL_STRENGTH_W > DATA_W)
  begin : g_signal_strength_w_check
    $error("radio_packet_status_regs: SIGNAL_STRENGTH_W must lie between 1 and 32");
  end

  if (BIT_COUNT_W < 1 || BIT_COUNT_W > DATA_W)
  begin : g_bit_count_w_check
    $error("radio_packet_status_regs: BIT_COUNT_W must lie between 1 and 32");
  end

  if (EVENT_COUNT > DATA_W)
  begin : g_event_count_check
    $error("radio_packet_status_regs: event vector wider than the bus word");
  end

  typedef logic [EVENT_COUNT-1:0] event_t;

  // Whole state of the bank
  typedef struct packed {
    event_t int_enable;
    event_t event_status;
    logic check_status;
    logic [LOGICAL_ADDR_W-1:0] logical_address;
    logic [CHECK_FIELD_W-1:0] check_field;
    logic [DEVICE_INDEX_W-1:0] device_index;
    logic [31:0] packet_pointer;
    logic [SIGNAL_STRENGTH_W-1:0] signal_strength;
    logic [BIT_COUNT_W-1:0] bit_compare;
    logic waitrequest;
    logic [DATA_W-1:0] readdata;
    logic irq;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Merge write data into an old word under byte enables
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] lanes
  );
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
      begin
        result[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return result;
  endfunction : merge_bytes

  // Zero-extend a narrow field to a bus word
  function automatic logic [31:0] widen(input logic [31:0] value, input int width);
    logic [31:0] mask;
    mask = (width >= 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << width) - 32'h0000_0001);
    return value & mask;
  endfunction : widen

  // Combinational event vector and bus strobes
  event_t raised;
  logic request;
  logic accept;
  logic do_write;
  logic [31:0] write_word;
  logic [31:0] read_word;
  logic [31:0] merged_pointer;
  logic [31:0] merged_compare;
  logic wr_status;
  logic wr_enable_set;
  logic wr_disable;
  logic wr_pointer;
  logic wr_compare;

  // Gather this cycle's events from the radio core
  always_comb
  begin
    raised = '0;
    raised[EV_READY] = READY_STROBE;
    raised[EV_ADDRESS] = ADDRESS_STROBE;
    raised[EV_RECEIVED_A] = RECEIVED_A_STROBE;
    raised[EV_END] = END_STROBE;
    raised[EV_DISABLED] = DISABLED_STROBE;
    raised[EV_DEVICE_ADDRESS_HIT] = DEVICE_ADDRESS_HIT;
    raised[EV_DEVICE_ADDRESS_MISS] = DEVICE_ADDRESS_MISS;
    raised[EV_SIGNAL_STRENGTH_DONE] = SIGNAL_STRENGTH_VALID;
    raised[EV_BIT_COUNT_HIT] = BIT_COUNT_STEP && (BIT_COUNT == state_reg.bit_compare);
    raised[EV_CHECK_PASSED] = RX_DONE && RX_CHECK_OK;
    raised[EV_CHECK_FAILED] = RX_DONE && !RX_CHECK_OK;
  end

  // Bus handshake: reads sample in the first cycle, writes take effect in the second cycle, which answers
  assign request = READ || WRITE;
  assign accept = request && state_reg.waitrequest;
  assign do_write = WRITE && !state_reg.waitrequest;
  assign write_word = merge_bytes(32'h0000_0000, WRITEDATA, BYTEENABLE);
  assign merged_pointer = merge_bytes(state_reg.packet_pointer, WRITEDATA, BYTEENABLE);
  assign merged_compare = merge_bytes(widen(32'(state_reg.bit_compare), BIT_COUNT_W), WRITEDATA, BYTEENABLE);

  // Write strobes, one per writable register
  assign wr_status = do_write && (ADDRESS == OFS_EVENT_STATUS);
  assign wr_enable_set = do_write && (ADDRESS == OFS_INTERRUPT_ENABLE_SET);
  assign wr_disable = do_write && (ADDRESS == OFS_INTERRUPT_DISABLE);
  assign wr_pointer = do_write && (ADDRESS == OFS_PACKET_BUFFER_POINTER);
  assign wr_compare = do_write && (ADDRESS == OFS_BIT_COUNT_COMPARE);

  // Read multiplexer, unmapped offsets read zero
  always_comb
  begin
    read_word = UNMAPPED_READ;
    unique case (ADDRESS)
      OFS_INTERRUPT_ENABLE_SET,
      OFS_INTERRUPT_DISABLE: read_word = 32'(state_reg.int_enable);
      OFS_EVENT_STATUS: read_word = 32'(state_reg.event_status);
      OFS_CHECK_STATUS: read_word = 32'(state_reg.check_status);
      OFS_RECEIVED_LOGICAL_ADDRESS: read_word = widen(32'(state_reg.logical_address), LOGICAL_ADDR_W);
      OFS_RECEIVED_CHECK_FIELD: read_word = widen(32'(state_reg.check_field), CHECK_FIELD_W);
      OFS_MATCHED_DEVICE_INDEX: read_word = widen(32'(state_reg.device_index), DEVICE_INDEX_W);
      OFS_PACKET_BUFFER_POINTER: read_word = state_reg.packet_pointer;
      OFS_SIGNAL_STRENGTH_SAMPLE: read_word = widen(32'(state_reg.signal_strength), SIGNAL_STRENGTH_W);
      OFS_BIT_COUNT_COMPARE: read_word = widen(32'(state_reg.bit_compare), BIT_COUNT_W);
      default: read_word = UNMAPPED_READ;
    endcase
  end

  // Next-state logic
  always_comb
  begin
    state_next = state_reg;

    // Waitrequest drops for exactly one cycle per request
    state_next.waitrequest = !accept;
    if (accept && READ)
    begin
      state_next.readdata = read_word;
    end

    // Sticky status: write-one-to-clear, then set wins over clear
    if (wr_status)
    begin
      state_next.event_status = state_reg.event_status & ~write_word[EVENT_COUNT-1:0];
    end
    state_next.event_status = state_next.event_status | raised;

    // Enable set and disable; zero bits leave enables alone
    if (wr_enable_set)
    begin
      state_next.int_enable = state_reg.int_enable | write_word[EVENT_COUNT-1:0];
    end
    if (wr_disable)
    begin
      state_next.int_enable = state_reg.int_enable & ~write_word[EVENT_COUNT-1:0];
    end

    // Packet pointer, software must give a byte-aligned RAM address
    if (wr_pointer)
    begin
      state_next.packet_pointer = merged_pointer;
    end

    // Bit counter compare value
    if (wr_compare)
    begin
      state_next.bit_compare = merged_compare[BIT_COUNT_W-1:0];
    end

    // Capture at reception end, held until the next one
    // Bus writes never reach these read-only fields
    if (RX_DONE)
    begin
      state_next.check_status = RX_CHECK_OK ? CHECK_PASSED_CODE : CHECK_FAILED_CODE;
      state_next.logical_address = RX_LOGICAL_ADDRESS;
      state_next.check_field = RX_CHECK_FIELD;
    end

    // Matching device address entry
    if (DEVICE_ADDRESS_HIT)
    begin
      state_next.device_index = DEVICE_INDEX;
    end

    // New signal strength sample
    if (SIGNAL_STRENGTH_VALID)
    begin
      state_next.signal_strength = SIGNAL_STRENGTH_VALUE;
    end

    // Level interrupt from pending and enabled events
    state_next.irq = |(state_next.event_status & state_next.int_enable);
  end

  // State register with asynchronous reset to constants
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_reg.int_enable <= RST_INTERRUPT_ENABLE[EVENT_COUNT-1:0];
      state_reg.event_status <= '0;
      state_reg.check_status <= RST_CHECK_STATUS[0];
      state_reg.logical_address <= RST_CAPTURE[LOGICAL_ADDR_W-1:0];
      state_reg.check_field <= RST_CAPTURE[CHECK_FIELD_W-1:0];
      state_reg.device_index <= RST_CAPTURE[DEVICE_INDEX_W-1:0];
      state_reg.packet_pointer <= RST_PACKET_BUFFER_POINTER;
      state_reg.signal_strength <= RST_CAPTURE[SIGNAL_STRENGTH_W-1:0];
      state_reg.bit_compare <= RST_BIT_COUNT_COMPARE[BIT_COUNT_W-1:0];
      state_reg.waitrequest <= 1'b1;
      state_reg.readdata <= '0;
      state_reg.irq <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Ports straight from flip-flops
  assign READDATA = state_reg.readdata;
  assign WAITREQUEST = state_reg.waitrequest;
  assign PACKET_BUFFER_POINTER = state_reg.packet_pointer;
  assign IRQ = state_reg.irq;

endmodule : radio_packet_status_regs

// ---- core/radio_status_pkg.sv ----
/*
  Constants for the radio packet status register bank: byte offsets, reset values,
  event bit positions and field encodings.
  Assumes an Avalon-MM slave with 32-bit data and byte addressing on a 12-bit address.
*/
package radio_status_pkg;

  // Address and data geometry of the register window
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_INTERRUPT_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFS_INTERRUPT_DISABLE = 12'h308;
  localparam logic [11:0] OFS_CHECK_STATUS = 12'h400;
  localparam logic [11:0] OFS_RECEIVED_LOGICAL_ADDRESS = 12'h408;
  localparam logic [11:0] OFS_RECEIVED_CHECK_FIELD = 12'h40c;
  localparam logic [11:0] OFS_MATCHED_DEVICE_INDEX = 12'h410;
  localparam logic [11:0] OFS_PACKET_BUFFER_POINTER = 12'h504;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h600;
  localparam logic [11:0] OFS_SIGNAL_STRENGTH_SAMPLE = 12'h604;
  localparam logic [11:0] OFS_BIT_COUNT_COMPARE = 12'h608;

  // Event bit positions, shared by enable and sticky status registers
  localparam int EVENT_COUNT = 11;
  localparam int EV_READY = 0;
  localparam int EV_ADDRESS = 1;
  localparam int EV_RECEIVED_A = 2;
  localparam int EV_END = 3;
  localparam int EV_DISABLED = 4;
  localparam int EV_DEVICE_ADDRESS_HIT = 5;
  localparam int EV_DEVICE_ADDRESS_MISS = 6;
  localparam int EV_SIGNAL_STRENGTH_DONE = 7;
  localparam int EV_BIT_COUNT_HIT = 8;
  localparam int EV_CHECK_PASSED = 9;
  localparam int EV_CHECK_FAILED = 10;

  // Field encodings
  localparam logic CHECK_FAILED_CODE = 1'b0;
  localparam logic CHECK_PASSED_CODE = 1'b1;

  // Reset values
  localparam logic [31:0] RST_INTERRUPT_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_CHECK_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_PACKET_BUFFER_POINTER = 32'h0000_0000;
  localparam logic [31:0] RST_CAPTURE = 32'h0000_0000;
  localparam logic [31:0] RST_BIT_COUNT_COMPARE = 32'h0000_0000;

  // Value returned for an unmapped read
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage : radio_status_pkg

// ---- test/packet_ram_model.sv ----
/* Packet RAM at the far side of the pointer: fetches the byte the pointer names.
   Assumes a byte pointer into a 256-byte window, same clock as the bank. */
`timescale 1ns/1ps
module packet_ram_model (
  input wire logic clk,
  input wire logic [31:0] ptr,
  output logic [7:0] first_byte
);
  logic [7:0] mem [256];
  // Fixed content so any fetch is predictable
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end
  // Fetch at the pointed byte
  always_ff @(posedge clk)
    first_byte <= mem[ptr[7:0]];
endmodule : packet_ram_model

// ---- test/radio_packet_status_regs_tb.sv ----
/* Self-checking bench for the radio packet status bank over Avalon-MM.
   Assumes the package constants and the bound checker. */
`timescale 1ns/1ps
module radio_packet_status_regs_tb;
  import radio_status_pkg::*;
  logic CLK = 0, RST_N = 0, READ = 0, WRITE = 0, rx_ok = 0, WAITREQUEST, IRQ;
  logic [11:0] ADDRESS = '0;
  logic [31:0] WRITEDATA = '0, bc = '0, READDATA, PACKET_BUFFER_POINTER, q, v, en;
  logic [9:0] st = '0;
  logic [2:0] rx_la = '0, dev_ix = '0;
  logic [23:0] rx_cf = '0;
  logic [6:0] ss_val = '0;
  logic [7:0] ram_byte;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  radio_packet_status_regs i_dut (.CLK(CLK), .RST_N(RST_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .WRITEDATA(WRITEDATA), .BYTEENABLE(4'hf), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .READY_STROBE(st[0]), .ADDRESS_STROBE(st[1]), .RECEIVED_A_STROBE(st[2]), .END_STROBE(st[3]),
    .DISABLED_STROBE(st[4]), .DEVICE_ADDRESS_HIT(st[5]), .DEVICE_ADDRESS_MISS(st[6]), .DEVICE_INDEX(dev_ix),
    .RX_DONE(st[7]), .RX_CHECK_OK(rx_ok), .RX_LOGICAL_ADDRESS(rx_la), .RX_CHECK_FIELD(rx_cf),
    .SIGNAL_STRENGTH_VALID(st[8]), .SIGNAL_STRENGTH_VALUE(ss_val), .BIT_COUNT_STEP(st[9]), .BIT_COUNT(bc),
    .PACKET_BUFFER_POINTER(PACKET_BUFFER_POINTER), .IRQ(IRQ));
  packet_ram_model i_ram (.clk(CLK), .ptr(PACKET_BUFFER_POINTER), .first_byte(ram_byte));
  // Clock and hang guard
  initial
  begin
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    READ <= !w;
    WRITE <= w;
    ADDRESS <= a;
    WRITEDATA <= d;
    do @(posedge CLK); while (WAITREQUEST !== 1'b0);
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, '0);
    chk(nm, q, exp);
  endtask : rchk
  task automatic pulse(input int i);
    @(posedge CLK);
    st <= 10'(1) << i;
    @(posedge CLK);
    st <= '0;
  endtask : pulse
  function automatic logic [31:0] ram_exp(input logic [31:0] p);
    return {24'h00_0000, p[7:0] ^ 8'h5a};
  endfunction : ram_exp
  // Main sequence
  initial
  begin
    void'($urandom(38815));
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    rchk(OFS_INTERRUPT_DISABLE, 32'h0000_0000, "enable reset");
    rchk(OFS_CHECK_STATUS, 32'h0000_0000, "check reset");
    rchk(OFS_PACKET_BUFFER_POINTER, 32'h0000_0000, "pointer reset");
    rchk(12'h0ff, 32'h0000_0000, "unmapped");
    en = '0;
    for (int i = 0; i < 24; i++)
    begin
      v = (i < 11) ? 32'h0000_07ff : $urandom & 32'h0000_07ff;
      bus(1'b1, OFS_INTERRUPT_ENABLE_SET, v);
      en = en | v;
      v = (i < 11) ? 32'h1 << i : $urandom;
      bus(1'b1, OFS_INTERRUPT_DISABLE, v);
      en = en & ~v;
      rchk(OFS_INTERRUPT_DISABLE, en, "enables");
      rchk(OFS_INTERRUPT_ENABLE_SET, en, "enables set view");
    end
    bus(1'b1, OFS_INTERRUPT_ENABLE_SET, 32'h0000_07ff);
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, OFS_EVENT_STATUS, 32'h0000_07ff);
      pulse(i);
      @(posedge CLK);
      chk("irq", {31'h0, IRQ}, 32'h1);
      rchk(OFS_EVENT_STATUS, 32'h1 << i, "event");
    end
    bus(1'b1, OFS_INTERRUPT_DISABLE, 32'h0000_0000);
    @(posedge CLK);
    chk("irq kept", {31'h0, IRQ}, 32'h1);
    bus(1'b1, OFS_INTERRUPT_DISABLE, 32'h0000_07ff);
    @(posedge CLK);
    chk("irq off", {31'h0, IRQ}, 32'h0);
    repeat (6)
    begin
      {rx_ok, rx_la, rx_cf, dev_ix, ss_val} <= {6'($urandom), 32'($urandom)};
      bus(1'b1, OFS_EVENT_STATUS, 32'h0000_07ff);
      pulse(7);
      pulse(5);
      pulse(8);
      rchk(OFS_CHECK_STATUS, {31'h0, rx_ok}, "check status");
      rchk(OFS_RECEIVED_LOGICAL_ADDRESS, {29'h0, rx_la}, "logical address");
      rchk(OFS_RECEIVED_CHECK_FIELD, {8'h0, rx_cf}, "check field");
      rchk(OFS_MATCHED_DEVICE_INDEX, {29'h0, dev_ix}, "device index");
      rchk(OFS_SIGNAL_STRENGTH_SAMPLE, {25'h0, ss_val}, "strength");
      rchk(OFS_EVENT_STATUS, rx_ok ? 32'h0000_02a0 : 32'h0000_04a0, "rx events");
      {rx_ok, rx_cf} <= ~{rx_ok, rx_cf};
      bus(1'b1, OFS_CHECK_STATUS, 32'hffff_ffff);
      rchk(OFS_CHECK_STATUS, {31'h0, ~rx_ok}, "status held");
      rchk(OFS_RECEIVED_CHECK_FIELD, {8'h0, ~rx_cf}, "field held");
    end
    v = $urandom;
    bus(1'b1, OFS_BIT_COUNT_COMPARE, v);
    bus(1'b1, OFS_EVENT_STATUS, 32'h0000_07ff);
    bc <= v ^ 32'h0000_0001;
    pulse(9);
    rchk(OFS_EVENT_STATUS, 32'h0000_0000, "count miss");
    bc <= v;
    pulse(9);
    rchk(OFS_EVENT_STATUS, 32'h0000_0100, "count hit");
    repeat (4)
    begin
      v = $urandom;
      bus(1'b1, OFS_PACKET_BUFFER_POINTER, v);
      rchk(OFS_PACKET_BUFFER_POINTER, v, "pointer");
      chk("pointer port", PACKET_BUFFER_POINTER, v);
      chk("fetched byte", {24'h0, ram_byte}, ram_exp(v));
    end
    give_verdict();
  end
endmodule : radio_packet_status_regs_tb

// ---- test/radio_status_chk.sv ----
/* Checker for the radio packet status bank: bus answer timing, pointer, enables and IRQ.
   Assumes it is bound to the bank's top module, one clock domain. */
`timescale 1ns/1ps
module radio_status_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [radio_status_pkg::ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [radio_status_pkg::DATA_W-1:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [radio_status_pkg::DATA_W-1:0] READDATA,
  input wire logic WAITREQUEST,
  input wire logic [31:0] PACKET_BUFFER_POINTER,
  input wire logic IRQ
);
  import radio_status_pkg::*;
  logic wr_ack;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Write accepted in this cycle
  assign wr_ack = WRITE && !WAITREQUEST;
  property p_answer; (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_ptr_load; wr_ack && ADDRESS == OFS_PACKET_BUFFER_POINTER && BYTEENABLE == 4'hf
    |=> PACKET_BUFFER_POINTER == $past(WRITEDATA); endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");
  property p_ptr_hold; !(wr_ack && ADDRESS == OFS_PACKET_BUFFER_POINTER) |=> $stable(PACKET_BUFFER_POINTER);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved");
  property p_irq_off; wr_ack && ADDRESS == OFS_INTERRUPT_DISABLE && WRITEDATA[10:0] == 11'h7ff
    && BYTEENABLE == 4'hf |=> !IRQ; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq after full disable");
  property p_zero_keep; IRQ && wr_ack && ADDRESS == OFS_INTERRUPT_DISABLE && WRITEDATA == '0 |=> IRQ; endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("zero write dropped irq");
  property p_irq_hold; IRQ && !WRITE |=> IRQ; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq fell without write");
  property p_check_bit; READ && !WAITREQUEST && ADDRESS == OFS_CHECK_STATUS |-> READDATA[31:1] == '0; endproperty
  a_check_bit: assert property (p_check_bit) else $error("check status wide");
  property p_en_layout; READ && !WAITREQUEST && ADDRESS == OFS_INTERRUPT_DISABLE |-> READDATA[31:11] == '0;
  endproperty
  a_en_layout: assert property (p_en_layout) else $error("enable bits out of field");
endmodule : radio_status_chk
bind radio_packet_status_regs radio_status_chk i_chk (.CLK(CLK), .RST_N(RST_N), .ADDRESS(ADDRESS), .READ(READ),
  .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .PACKET_BUFFER_POINTER(PACKET_BUFFER_POINTER), .IRQ(IRQ));
